/* design/pdpc_regs_defs.vh */
`ifndef PDPC_REGS_DEFS_VH
`define PDPC_REGS_DEFS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PDPC_ADDR_PLAY_PWR    16'h4029
`define PDPC_ADDR_CONV_CTL0   16'h402A
`define PDPC_ADDR_LEFT_ATTN   16'h402B
`define PDPC_ADDR_RIGHT_ATTN  16'h402C
`define PDPC_ADDR_SER_PADS    16'h402D
`define PDPC_ADDR_CTL_PADS    16'h402F
`define PDPC_ADDR_CTL_DRIVE   16'h4030
`define PDPC_ADDR_JACK_CFG    16'h4031
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDPC_RST_ZERO         8'h00
`define PDPC_RST_PULLS        8'hAA
`define PDPC_RST_JACK         8'h08
// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define PDPC_MASK_FULL        8'hFF
`define PDPC_MASK_CONV_CTL0   8'hE7
`define PDPC_MASK_CTL_DRIVE   8'h01
`define PDPC_MASK_JACK_CFG    8'h2C
// ----------------------------------------
// Slew timing
// ----------------------------------------
`define PDPC_SLEW_STEP_CYC    16'h0040
`define PDPC_SLEW_CNT_ZERO    16'h0000
`define PDPC_SLEW_CNT_DEC     16'h0001
`define PDPC_ATTEN_STEP       8'h01
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDPC_PLAY_LEFT_BIT    0
`define PDPC_PLAY_RIGHT_BIT   1
`define PDPC_HP_BIAS_HI       7
`define PDPC_HP_BIAS_LO       6
`define PDPC_CONV_BIAS_HI     5
`define PDPC_CONV_BIAS_LO     4
`define PDPC_PATH_BIAS_HI     3
`define PDPC_PATH_BIAS_LO     2
`define PDPC_MONO_HI          7
`define PDPC_MONO_LO          6
`define PDPC_INVERT_BIT       5
`define PDPC_DEEMPH_BIT       2
`define PDPC_CONV_EN_HI       1
`define PDPC_CONV_EN_LO       0
`define PDPC_PULL3_HI         7
`define PDPC_PULL3_LO         6
`define PDPC_PULL2_HI         5
`define PDPC_PULL2_LO         4
`define PDPC_PULL1_HI         3
`define PDPC_PULL1_LO         2
`define PDPC_PULL0_HI         1
`define PDPC_PULL0_LO         0
`define PDPC_CTL_DRIVE_BIT    0
`define PDPC_JACK_DRIVE_BIT   5
`define PDPC_JACK_PULL_HI     3
`define PDPC_JACK_PULL_LO     2
// ----------------------------------------
// Field reset values
// ----------------------------------------
`define PDPC_FLD_OFF          1'h0
`define PDPC_FLD_ZERO2        2'h0
`define PDPC_FLD_PULL_NONE    2'h2
`endif

/* design/pdpc_regs.v */
`include "pdpc_regs_defs.vh"
`default_nettype none
module pdpc_regs #(
   parameter [15:0] SLEW_STEP_CYC = `PDPC_SLEW_STEP_CYC
) (
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_srst,
   // Control port access
   input  wire [15:0] i_addr,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [7:0]  i_wdata,
   output reg  [7:0]  o_rdata,
   output reg         o_hit,
   // Playback power
   output reg         o_play_left_en,
   output reg         o_play_right_en,
   output reg  [1:0]  o_headphone_bias_sel,
   output reg  [1:0]  o_converter_bias_sel,
   output reg  [1:0]  o_play_path_bias_sel,
   // Converter control
   output reg  [1:0]  o_converter_mono_sel,
   output reg         o_converter_invert,
   output reg         o_deemphasis_en,
   output reg  [1:0]  o_converter_enable_sel,
   output reg  [7:0]  o_left_applied_atten,
   output reg  [7:0]  o_right_applied_atten,
   // Pads
   output reg  [1:0]  o_rec_data_pad_pull,
   output reg  [1:0]  o_play_data_pad_pull,
   output reg  [1:0]  o_frame_clock_pad_pull,
   output reg  [1:0]  o_bit_clock_pad_pull,
   output reg  [1:0]  o_ctrl_dout_pad_pull,
   output reg  [1:0]  o_ctrl_latch_pad_pull,
   output reg  [1:0]  o_ctrl_clock_pad_pull,
   output reg  [1:0]  o_ctrl_data_pad_pull,
   output reg         o_ctrl_data_drive_high,
   output reg         o_jack_pin_drive_high,
   output reg  [1:0]  o_jack_pin_pull
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [7:0]  play_pwr_ff;
   reg [7:0]  conv_ctl0_ff;
   reg [7:0]  left_atten_ff;
   reg [7:0]  right_atten_ff;
   reg [7:0]  ser_pads_ff;
   reg [7:0]  ctl_pads_ff;
   reg [7:0]  ctl_drive_ff;
   reg [7:0]  jack_cfg_ff;
   reg [7:0]  left_slew_ff;
   reg [7:0]  right_slew_ff;
   reg [15:0] slew_cnt_ff;
   reg [7:0]  nxt_rdata;
   reg        nxt_hit;
   wire       slew_tick;
   wire       wr_play_pwr;
   wire       wr_conv_ctl0;
   wire       wr_left_atten;
   wire       wr_right_atten;
   wire       wr_ser_pads;
   wire       wr_ctl_pads;
   wire       wr_ctl_drive;
   wire       wr_jack_cfg;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [7:0] step_toward;
      input [7:0] cur;
      input [7:0] tgt;
      begin
         if (cur < tgt) begin
            step_toward = cur + `PDPC_ATTEN_STEP;
         end else if (cur > tgt) begin
            step_toward = cur - `PDPC_ATTEN_STEP;
         end else begin
            step_toward = cur;
         end
      end
   endfunction

   function hit_at;
      input [15:0] a;
      input [15:0] b;
      begin
         hit_at = i_wr && (a == b);
      end
   endfunction

   // ----------------------------------------
   // Write strobes
   // ----------------------------------------
   assign wr_play_pwr    = hit_at(i_addr, `PDPC_ADDR_PLAY_PWR);
   assign wr_conv_ctl0   = hit_at(i_addr, `PDPC_ADDR_CONV_CTL0);
   assign wr_left_atten  = hit_at(i_addr, `PDPC_ADDR_LEFT_ATTN);
   assign wr_right_atten = hit_at(i_addr, `PDPC_ADDR_RIGHT_ATTN);
   assign wr_ser_pads    = hit_at(i_addr, `PDPC_ADDR_SER_PADS);
   assign wr_ctl_pads    = hit_at(i_addr, `PDPC_ADDR_CTL_PADS);
   assign wr_ctl_drive   = hit_at(i_addr, `PDPC_ADDR_CTL_DRIVE);
   assign wr_jack_cfg    = hit_at(i_addr, `PDPC_ADDR_JACK_CFG);

   // ----------------------------------------
   // Playback power register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         play_pwr_ff <= `PDPC_RST_ZERO;
      end else if (wr_play_pwr) begin
         play_pwr_ff <= i_wdata & `PDPC_MASK_FULL;
      end
   end

   // ----------------------------------------
   // Converter control register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         conv_ctl0_ff <= `PDPC_RST_ZERO;
      end else if (wr_conv_ctl0) begin
         conv_ctl0_ff <= i_wdata & `PDPC_MASK_CONV_CTL0;
      end
   end

   // ----------------------------------------
   // Left attenuation register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         left_atten_ff <= `PDPC_RST_ZERO;
      end else if (wr_left_atten) begin
         left_atten_ff <= i_wdata;
      end
   end

   // ----------------------------------------
   // Right attenuation register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         right_atten_ff <= `PDPC_RST_ZERO;
      end else if (wr_right_atten) begin
         right_atten_ff <= i_wdata;
      end
   end

   // ----------------------------------------
   // Serial audio pad register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         ser_pads_ff <= `PDPC_RST_PULLS;
      end else if (wr_ser_pads) begin
         ser_pads_ff <= i_wdata;
      end
   end

   // ----------------------------------------
   // Control port pad register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         ctl_pads_ff <= `PDPC_RST_PULLS;
      end else if (wr_ctl_pads) begin
         ctl_pads_ff <= i_wdata;
      end
   end

   // ----------------------------------------
   // Control data drive register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         ctl_drive_ff <= `PDPC_RST_ZERO;
      end else if (wr_ctl_drive) begin
         ctl_drive_ff <= i_wdata & `PDPC_MASK_CTL_DRIVE;
      end
   end

   // ----------------------------------------
   // Jack pin register
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         jack_cfg_ff <= `PDPC_RST_JACK;
      end else if (wr_jack_cfg) begin
         jack_cfg_ff <= i_wdata & `PDPC_MASK_JACK_CFG;
      end
   end

   // ----------------------------------------
   // Slew timer
   // ----------------------------------------
   assign slew_tick = (slew_cnt_ff == `PDPC_SLEW_CNT_ZERO);

   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         slew_cnt_ff <= `PDPC_SLEW_CNT_ZERO;
      end else if (slew_tick) begin
         slew_cnt_ff <= SLEW_STEP_CYC - `PDPC_SLEW_CNT_DEC;
      end else begin
         slew_cnt_ff <= slew_cnt_ff - `PDPC_SLEW_CNT_DEC;
      end
   end

   // ----------------------------------------
   // Attenuation slewing
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         left_slew_ff  <= `PDPC_RST_ZERO;
         right_slew_ff <= `PDPC_RST_ZERO;
      end else if (slew_tick) begin
         left_slew_ff  <= step_toward(left_slew_ff, left_atten_ff);
         right_slew_ff <= step_toward(right_slew_ff, right_atten_ff);
      end
   end

   // ----------------------------------------
   // Read decode
   // ----------------------------------------
   always @* begin
      nxt_hit   = 1'b1;
      nxt_rdata = `PDPC_RST_ZERO;
      case (i_addr)
         `PDPC_ADDR_PLAY_PWR:   nxt_rdata = play_pwr_ff;
         `PDPC_ADDR_CONV_CTL0:  nxt_rdata = conv_ctl0_ff;
         `PDPC_ADDR_LEFT_ATTN:  nxt_rdata = left_atten_ff;
         `PDPC_ADDR_RIGHT_ATTN: nxt_rdata = right_atten_ff;
         `PDPC_ADDR_SER_PADS:   nxt_rdata = ser_pads_ff;
         `PDPC_ADDR_CTL_PADS:   nxt_rdata = ctl_pads_ff;
         `PDPC_ADDR_CTL_DRIVE:  nxt_rdata = ctl_drive_ff;
         `PDPC_ADDR_JACK_CFG:   nxt_rdata = jack_cfg_ff;
         default:               nxt_hit   = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Read answer
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_rdata <= `PDPC_RST_ZERO;
         o_hit   <= 1'b0;
      end else begin
         o_rdata <= i_rd ? nxt_rdata : `PDPC_RST_ZERO;
         o_hit   <= (i_rd || i_wr) && nxt_hit;
      end
   end

   // ----------------------------------------
   // Playback power fields
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_play_left_en       <= `PDPC_FLD_OFF;
         o_play_right_en      <= `PDPC_FLD_OFF;
         o_headphone_bias_sel <= `PDPC_FLD_ZERO2;
         o_converter_bias_sel <= `PDPC_FLD_ZERO2;
         o_play_path_bias_sel <= `PDPC_FLD_ZERO2;
      end else begin
         o_play_left_en       <= play_pwr_ff[`PDPC_PLAY_LEFT_BIT];
         o_play_right_en      <= play_pwr_ff[`PDPC_PLAY_RIGHT_BIT];
         o_headphone_bias_sel <= play_pwr_ff[`PDPC_HP_BIAS_HI:`PDPC_HP_BIAS_LO];
         o_converter_bias_sel <= play_pwr_ff[`PDPC_CONV_BIAS_HI:`PDPC_CONV_BIAS_LO];
         o_play_path_bias_sel <= play_pwr_ff[`PDPC_PATH_BIAS_HI:`PDPC_PATH_BIAS_LO];
      end
   end

   // ----------------------------------------
   // Converter control fields
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_converter_mono_sel   <= `PDPC_FLD_ZERO2;
         o_converter_invert     <= `PDPC_FLD_OFF;
         o_deemphasis_en        <= `PDPC_FLD_OFF;
         o_converter_enable_sel <= `PDPC_FLD_ZERO2;
      end else begin
         o_converter_mono_sel   <= conv_ctl0_ff[`PDPC_MONO_HI:`PDPC_MONO_LO];
         o_converter_invert     <= conv_ctl0_ff[`PDPC_INVERT_BIT];
         o_deemphasis_en        <= conv_ctl0_ff[`PDPC_DEEMPH_BIT];
         o_converter_enable_sel <= conv_ctl0_ff[`PDPC_CONV_EN_HI:`PDPC_CONV_EN_LO];
      end
   end

   // ----------------------------------------
   // Applied attenuation
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_left_applied_atten  <= `PDPC_RST_ZERO;
         o_right_applied_atten <= `PDPC_RST_ZERO;
      end else begin
         o_left_applied_atten  <= left_slew_ff;
         o_right_applied_atten <= right_slew_ff;
      end
   end

   // ----------------------------------------
   // Serial audio pad fields
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_rec_data_pad_pull    <= `PDPC_FLD_PULL_NONE;
         o_play_data_pad_pull   <= `PDPC_FLD_PULL_NONE;
         o_frame_clock_pad_pull <= `PDPC_FLD_PULL_NONE;
         o_bit_clock_pad_pull   <= `PDPC_FLD_PULL_NONE;
      end else begin
         o_rec_data_pad_pull    <= ser_pads_ff[`PDPC_PULL3_HI:`PDPC_PULL3_LO];
         o_play_data_pad_pull   <= ser_pads_ff[`PDPC_PULL2_HI:`PDPC_PULL2_LO];
         o_frame_clock_pad_pull <= ser_pads_ff[`PDPC_PULL1_HI:`PDPC_PULL1_LO];
         o_bit_clock_pad_pull   <= ser_pads_ff[`PDPC_PULL0_HI:`PDPC_PULL0_LO];
      end
   end

   // ----------------------------------------
   // Control port pad fields
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_ctrl_dout_pad_pull  <= `PDPC_FLD_PULL_NONE;
         o_ctrl_latch_pad_pull <= `PDPC_FLD_PULL_NONE;
         o_ctrl_clock_pad_pull <= `PDPC_FLD_PULL_NONE;
         o_ctrl_data_pad_pull  <= `PDPC_FLD_PULL_NONE;
      end else begin
         o_ctrl_dout_pad_pull  <= ctl_pads_ff[`PDPC_PULL3_HI:`PDPC_PULL3_LO];
         o_ctrl_latch_pad_pull <= ctl_pads_ff[`PDPC_PULL2_HI:`PDPC_PULL2_LO];
         o_ctrl_clock_pad_pull <= ctl_pads_ff[`PDPC_PULL1_HI:`PDPC_PULL1_LO];
         o_ctrl_data_pad_pull  <= ctl_pads_ff[`PDPC_PULL0_HI:`PDPC_PULL0_LO];
      end
   end

   // ----------------------------------------
   // Drive and jack pin fields
   // ----------------------------------------
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_ctrl_data_drive_high <= `PDPC_FLD_OFF;
         o_jack_pin_drive_high  <= `PDPC_FLD_OFF;
         o_jack_pin_pull        <= `PDPC_FLD_PULL_NONE;
      end else begin
         o_ctrl_data_drive_high <= ctl_drive_ff[`PDPC_CTL_DRIVE_BIT];
         o_jack_pin_drive_high  <= jack_cfg_ff[`PDPC_JACK_DRIVE_BIT];
         o_jack_pin_pull        <= jack_cfg_ff[`PDPC_JACK_PULL_HI:`PDPC_JACK_PULL_LO];
      end
   end

endmodule
`default_nettype wire

/* verification/pdpc_regs_chk.sv */
`default_nettype none
module pdpc_regs_chk (
   // Access
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   input wire logic [15:0] i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  i_wdata,
   // Outputs
   input wire logic [7:0]  o_rdata,
   input wire logic        o_hit,
   input wire logic        o_play_left_en,
   input wire logic        o_converter_invert,
   input wire logic        o_ctrl_data_drive_high,
   input wire logic        o_jack_pin_drive_high,
   input wire logic [7:0]  o_left_applied_atten
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   property p_gap; (i_wr || i_rd) && i_addr == 16'h402e |=> !o_hit && o_rdata == 8'h00; endproperty
   a_gap: assert property (p_gap) else $error("gap address answered");
   property p_jrd; i_rd && i_addr == 16'h4031 |=> o_hit && o_rdata[7:6] == 2'b00 && !o_rdata[4]; endproperty
   a_jrd: assert property (p_jrd) else $error("jack read wrong");
   property p_drd; i_rd && i_addr == 16'h4030 |=> o_hit && o_rdata[7:1] == 7'h00; endproperty
   a_drd: assert property (p_drd) else $error("drive read wrong");
   property p_play; i_wr && i_addr == 16'h4029 |-> ##2 o_play_left_en == $past(i_wdata[0], 2); endproperty
   a_play: assert property (p_play) else $error("left enable wrong");
   property p_inv; i_wr && i_addr == 16'h402a |-> ##2 o_converter_invert == $past(i_wdata[5], 2); endproperty
   a_inv: assert property (p_inv) else $error("invert wrong");
   property p_sda; i_wr && i_addr == 16'h4030 |-> ##2 o_ctrl_data_drive_high == $past(i_wdata[0], 2); endproperty
   a_sda: assert property (p_sda) else $error("data drive wrong");
   property p_jdr; i_wr && i_addr == 16'h4031 |-> ##2 o_jack_pin_drive_high == $past(i_wdata[5], 2); endproperty
   a_jdr: assert property (p_jdr) else $error("jack drive wrong");
   property p_slew; !$past(i_srst) && !$past(i_srst, 2) && !$stable(o_left_applied_atten) |->
      8'(o_left_applied_atten - $past(o_left_applied_atten)) == 8'h01 ||
      8'($past(o_left_applied_atten) - o_left_applied_atten) == 8'h01; endproperty
   a_slew: assert property (p_slew) else $error("atten jumped");
endmodule
bind pdpc_regs pdpc_regs_chk i_pdpc_regs_chk (.*);
`default_nettype wire

/* verification/pdpc_regs_bench.sv */
`default_nettype none
module pdpc_regs_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_ref_clk, i_srst, i_wr, i_rd;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, m[8];
   wire [7:0] o_rdata, o_left_applied_atten, o_right_applied_atten;
   wire o_hit, o_play_left_en, o_play_right_en, o_converter_invert, o_deemphasis_en, o_ctrl_data_drive_high,
      o_jack_pin_drive_high;
   wire [1:0] o_headphone_bias_sel, o_converter_bias_sel, o_play_path_bias_sel, o_converter_mono_sel,
      o_converter_enable_sel, o_rec_data_pad_pull, o_play_data_pad_pull, o_frame_clock_pad_pull,
      o_bit_clock_pad_pull, o_ctrl_dout_pad_pull, o_ctrl_latch_pad_pull, o_ctrl_clock_pad_pull,
      o_ctrl_data_pad_pull, o_jack_pin_pull;
   int bad_count, n_compared, j;
   localparam logic [7:0] K [8] = '{8'hff, 8'he7, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h2c};
   pdpc_regs #(.SLEW_STEP_CYC(16'h0002)) i_pdpc_regs (.*);
   function automatic logic [15:0] ad(int i);
      return 16'(16'h4029 + i + (i > 4));
   endfunction
   task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      for (int i = 0; i < 8; i++) if (ad(i) == a) m[i] = d & K[i];
      #1 chk("wr_hit", {7'h00, o_hit}, {7'h00, a != 16'h402e});
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] exp);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk("rdata", o_rdata, exp);
      chk("rd_hit", {7'h00, o_hit}, {7'h00, a != 16'h402e});
   endtask
   task automatic fields;
      int n;
      n = 0;
      repeat (2) @(posedge i_ref_clk);
      while (n < 600 && (o_left_applied_atten !== m[2] || o_right_applied_atten !== m[3])) begin
         @(posedge i_ref_clk);
         n++;
      end
      #1 chk("pwr", {o_headphone_bias_sel, o_converter_bias_sel, o_play_path_bias_sel, o_play_right_en,
         o_play_left_en}, m[0]);
      chk("conv", {o_converter_mono_sel, o_converter_invert, 2'b00, o_deemphasis_en, o_converter_enable_sel},
         m[1]);
      chk("latt", o_left_applied_atten, m[2]);
      chk("ratt", o_right_applied_atten, m[3]);
      chk("spad", {o_rec_data_pad_pull, o_play_data_pad_pull, o_frame_clock_pad_pull, o_bit_clock_pad_pull},
         m[4]);
      chk("cpad", {o_ctrl_dout_pad_pull, o_ctrl_latch_pad_pull, o_ctrl_clock_pad_pull, o_ctrl_data_pad_pull},
         m[5]);
      chk("cdrv", {7'h00, o_ctrl_data_drive_high}, m[6]);
      chk("jack", {2'b00, o_jack_pin_drive_high, 1'b0, o_jack_pin_pull, 2'b00}, m[7]);
      for (int i = 0; i < 9; i++) rd(i < 8 ? ad(i) : 16'h402e, i < 8 ? m[i] : 8'h00);
   endtask
   task automatic rst(int c);
      @(posedge i_ref_clk);
      i_srst <= 1'b1;
      repeat (c) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'haa, 8'haa, 8'h00, 8'h08};
      fields;
      $display("reset test done");
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      repeat (30000) @(posedge i_ref_clk);
      bad_count++;
      results;
   end
   initial begin
      {i_wr, i_rd, i_addr, i_wdata} = '0;
      i_srst = 1'b1;
      j = $urandom(32'hd437);
      rst(12);
      wr(16'h402b, 8'h05);
      repeat (4) @(posedge i_ref_clk);
      #1 chk("slew_mid", {7'h00, o_left_applied_atten == 8'h05}, 8'h00);
      fields;
      $display("slew test done");
      for (int i = 0; i < 40; i++) begin
         j = $urandom % 9;
         wr(j < 8 ? ad(j) : 16'h402e, 8'($urandom));
      end
      fields;
      $display("random test done");
      rst(2);
      results;
   end
endmodule
`default_nettype wire
